// *** design/eac_pkg.sv ***
// Purpose: constants and types for the energy accumulator config block
// Assumes: two-wire bus sampled on a free-running link clock
// Notes: command codes index the device's register map

package eac_pkg;

    // bus address and command codes
    localparam logic [6:0] DEV_ADDR = 7'h40;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_ENERGY_READOUT = 8'h86;
    localparam logic [7:0] CMD_ALERT_MASK = 8'hd2;
    localparam logic [7:0] CMD_DEVICE_CONFIG = 8'hd5;
    localparam logic [7:0] CMD_ENERGY_CLEAR = 8'hd6;
    localparam logic [7:0] CMD_MAKER_ID = 8'he0;

    // arbitrary value, not tied to any maker
    localparam logic [15:0] MAKER_ID_VALUE = 16'h1234;

    // device configuration fields
    localparam int CFG_MISMATCH_BIT = 7;
    localparam int CFG_MODE_LSB = 4;
    localparam int CFG_FILTER_DIS_BIT = 3;
    localparam int CFG_AUTOCLR_BIT = 2;
    localparam int CFG_ALERT_LATCH_BIT = 1;
    localparam int CFG_ALERT_POL_BIT = 0;
    localparam logic [7:0] CFG_RESET = 8'h02;
    localparam logic [7:0] MASK_RESET = 8'hf0;

    // accumulation modes
    localparam logic [1:0] MODE_SUM_ALL_A = 2'h0;
    localparam logic [1:0] MODE_POS_ONLY = 2'h1;
    localparam logic [1:0] MODE_NEG_ONLY = 2'h2;
    localparam logic [1:0] MODE_SUM_ALL_B = 2'h3;

    // input glitch filter length in link clock samples
    localparam int FILTER_LEN = 3;

    typedef enum logic [1:0] {
        EV_CMD = 2'h0,
        EV_WR = 2'h1,
        EV_STOP = 2'h2,
        EV_RDONE = 2'h3
    } eac_ev_kind_type;

    typedef struct packed {
        eac_ev_kind_type kind;
        logic [7:0] cmd;
        logic [7:0] data;
    } eac_event_type;

    typedef struct packed {
        logic valid;
        logic neg;
        logic [15:0] power;
    } eac_sample_type;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR = 8'h02,
        ST_CMD = 8'h04,
        ST_WDATA = 8'h08,
        ST_ACK = 8'h10,
        ST_RDATA = 8'h20,
        ST_MACK = 8'h40,
        ST_WAIT = 8'h80
    } eac_link_state_type;

endpackage

// *** design/eac_energy_accum_config.sv ***
// Purpose: config register, clear command and id word of an energy
//          accumulator, reached over a two-wire bus
// Assumes: link_clk runs free and much faster than the bus clock line
// Notes: bus engine on link_clk, registers on clock, toggle handshake
//
// How it works
// - equal mode codes add every reading
// - mode one adds positive-current readings only
// - mode two adds negative-current readings only
// - sum-everything modes never set the flag
// - clear-after-read bit clears after energy read
// - bit 3 bypasses the bus input filter
// - bit 1 selects latched or transparent alert
// - bit 0 inverts alert output level
// - bit 6 plain storage, no effect
// - dataless clear command resets energy and count
// - clear may drop one in-flight sample
// - id command returns fixed 16-bit word
// - configuration register is 8 bits at D5h
// - set mask bits block status from alert

`timescale 1ns/1ps

module eac_energy_accum_config
    import eac_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire eac_sample_type sample,
    input wire logic [7:0] vendor_status,
    output logic alert
);

    // ---------------- link domain ----------------
    logic [1:0] lrst_r;
    logic link_rst;
    logic [1:0] scl_s_r;
    logic [1:0] sda_s_r;
    logic [1:0] fd_s_r;
    logic [FILTER_LEN-1:0] scl_h_r;
    logic [FILTER_LEN-1:0] sda_h_r;
    logic scl_f_r;
    logic sda_f_r;
    logic scl_d_r;
    logic sda_d_r;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    eac_link_state_type st_r;
    eac_link_state_type next_st_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [7:0] cmd_r;
    logic cmd_seen_r;
    logic wdata_seen_r;
    logic read_seen_r;
    logic ack_on_r;
    logic [1:0] rd_idx_r;
    logic sda_oe_r;
    logic sda_out_r;
    logic [7:0] rbyte;
    logic byte_done;
    logic fire;
    eac_event_type fire_ev;
    eac_event_type ev_r;
    logic ev_tgl_r;
    logic busy_r;
    logic [2:0] ak_s_r;
    logic ack_edge;
    logic [31:0] snap_r;
    logic ack_tgl_r;
    logic [7:0] cfg_r;
    logic [31:0] snap_word_r;

    // reset release is synchronised to the link clock
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            lrst_r <= 2'h3;
        end else begin
            lrst_r <= {lrst_r[0], 1'b0};
        end
    end
    assign link_rst = lrst_r[1];

    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            fd_s_r <= 2'h0;
        end else begin
            scl_s_r <= {scl_s_r[0], scl_in};
            sda_s_r <= {sda_s_r[0], sda_in};
            fd_s_r <= {fd_s_r[0], cfg_r[CFG_FILTER_DIS_BIT]};
        end
    end

    // glitch filter: a level must hold for FILTER_LEN samples
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            scl_h_r <= '1;
            sda_h_r <= '1;
            scl_f_r <= 1'b1;
            sda_f_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_h_r <= {scl_h_r[FILTER_LEN-2:0], scl_s_r[1]};
            sda_h_r <= {sda_h_r[FILTER_LEN-2:0], sda_s_r[1]};
            scl_d_r <= scl_f_r;
            sda_d_r <= sda_f_r;
            if (fd_s_r[1]) begin
                scl_f_r <= scl_s_r[1];
                sda_f_r <= sda_s_r[1];
            end else begin
                if (&scl_h_r) scl_f_r <= 1'b1;
                else if (~|scl_h_r) scl_f_r <= 1'b0;
                if (&sda_h_r) sda_f_r <= 1'b1;
                else if (~|sda_h_r) sda_f_r <= 1'b0;
            end
        end
    end

    assign scl_rise = scl_f_r & ~scl_d_r;
    assign scl_fall = ~scl_f_r & scl_d_r;
    assign bus_start = scl_f_r & scl_d_r & sda_d_r & ~sda_f_r;
    assign bus_stop = scl_f_r & scl_d_r & ~sda_d_r & sda_f_r;
    assign shift_nxt = {shift_r[6:0], sda_f_r};
    assign byte_done = scl_rise & (bit_cnt_r == 3'h7);
    assign rbyte = snap_r[{rd_idx_r, 3'h0} +: 8];

    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            st_r <= ST_IDLE;
            next_st_r <= ST_IDLE;
            bit_cnt_r <= 3'h0;
            shift_r <= 8'h00;
            cmd_r <= 8'h00;
            cmd_seen_r <= 1'b0;
            wdata_seen_r <= 1'b0;
            read_seen_r <= 1'b0;
            ack_on_r <= 1'b0;
            rd_idx_r <= 2'h0;
            sda_oe_r <= 1'b0;
            sda_out_r <= 1'b0;
        end else if (bus_start) begin
            st_r <= ST_ADDR;
            bit_cnt_r <= 3'h0;
            ack_on_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (bus_stop) begin
            st_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
            cmd_seen_r <= 1'b0;
            wdata_seen_r <= 1'b0;
            read_seen_r <= 1'b0;
        end else begin
            case (st_r)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    if (scl_rise) begin
                        shift_r <= shift_nxt;
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                    end
                    if (byte_done) begin
                        st_r <= ST_ACK;
                        next_st_r <= ST_WDATA;
                        if (st_r == ST_ADDR) begin
                            rd_idx_r <= 2'h0;
                            if (shift_nxt[7:1] != DEV_ADDR) begin
                                st_r <= ST_WAIT;
                            end else if (shift_nxt[0]) begin
                                next_st_r <= ST_RDATA;
                            end else begin
                                next_st_r <= ST_CMD;
                            end
                        end else if (st_r == ST_CMD) begin
                            cmd_r <= shift_nxt;
                            cmd_seen_r <= 1'b1;
                            wdata_seen_r <= 1'b0;
                        end else begin
                            wdata_seen_r <= 1'b1;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (!ack_on_r) begin
                            ack_on_r <= 1'b1;
                            sda_oe_r <= 1'b1;
                        end else begin
                            ack_on_r <= 1'b0;
                            st_r <= next_st_r;
                            bit_cnt_r <= 3'h0;
                            if (next_st_r == ST_RDATA) begin
                                read_seen_r <= 1'b1;
                                sda_oe_r <= ~rbyte[7];
                            end else begin
                                sda_oe_r <= 1'b0;
                            end
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) sda_oe_r <= ~rbyte[~bit_cnt_r];
                    if (scl_rise) bit_cnt_r <= bit_cnt_r + 3'h1;
                    if (byte_done) st_r <= ST_MACK;
                end
                ST_MACK: begin
                    if (scl_fall) sda_oe_r <= 1'b0;
                    if (scl_rise) begin
                        if (!sda_f_r) begin
                            st_r <= ST_RDATA;
                            bit_cnt_r <= 3'h0;
                            rd_idx_r <= rd_idx_r + 2'h1;
                        end else begin
                            st_r <= ST_WAIT;
                        end
                    end
                end
                ST_IDLE, ST_WAIT: begin
                    sda_oe_r <= 1'b0;
                end
                default: begin
                    st_r <= ST_IDLE;
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // bus events handed to the register domain
    always_comb begin
        fire = 1'b0;
        fire_ev = '{kind: EV_CMD, cmd: cmd_r, data: shift_nxt};
        if (bus_stop && read_seen_r) begin
            fire = 1'b1;
            fire_ev.kind = EV_RDONE;
        end else if (bus_stop && cmd_seen_r && !wdata_seen_r) begin
            fire = 1'b1;
            fire_ev.kind = EV_STOP;
        end else if (byte_done && st_r == ST_CMD) begin
            fire = 1'b1;
            fire_ev.cmd = shift_nxt;
        end else if (byte_done && st_r == ST_WDATA) begin
            fire = 1'b1;
            fire_ev.kind = EV_WR;
        end
    end

    // bytes are far slower than the handshake, so busy drops nothing
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            ev_r <= '0;
            ev_tgl_r <= 1'b0;
            busy_r <= 1'b0;
        end else if (fire && !busy_r) begin
            ev_r <= fire_ev;
            ev_tgl_r <= ~ev_tgl_r;
            busy_r <= 1'b1;
        end else if (ack_edge) begin
            busy_r <= 1'b0;
        end
    end

    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            ak_s_r <= 3'h0;
            snap_r <= 32'h0;
        end else begin
            ak_s_r <= {ak_s_r[1:0], ack_tgl_r};
            if (ack_edge) snap_r <= snap_word_r;
        end
    end
    assign ack_edge = ak_s_r[2] ^ ak_s_r[1];
    assign sda_oe = sda_oe_r;
    assign sda_out = sda_out_r;

    // ---------------- register domain ----------------
    logic [2:0] rq_s_r;
    logic ev_edge;
    logic [7:0] mask_r;
    logic [15:0] accum_r;
    logic [15:0] count_r;
    logic alert_latch_r;
    logic alert_r;
    logic [1:0] mode;
    logic add_ok;
    logic mismatch;
    logic wr_cfg;
    logic wr_mask;
    logic clr_energy;
    logic clr_fault;
    logic alert_cond;
    logic alert_act;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rq_s_r <= 3'h0;
            ack_tgl_r <= 1'b0;
        end else begin
            rq_s_r <= {rq_s_r[1:0], ev_tgl_r};
            if (ev_edge) ack_tgl_r <= ~ack_tgl_r;
        end
    end
    assign ev_edge = rq_s_r[2] ^ rq_s_r[1];

    assign mode = cfg_r[CFG_MODE_LSB +: 2];
    assign add_ok = (mode == MODE_SUM_ALL_A) || (mode == MODE_SUM_ALL_B)
        || (mode == MODE_POS_ONLY && !sample.neg)
        || (mode == MODE_NEG_ONLY && sample.neg);
    assign mismatch = sample.valid &&
        ((mode == MODE_POS_ONLY && sample.neg) ||
         (mode == MODE_NEG_ONLY && !sample.neg));
    // id word is not decoded for writes
    assign wr_cfg = ev_edge && ev_r.kind == EV_WR &&
        ev_r.cmd == CMD_DEVICE_CONFIG;
    assign wr_mask = ev_edge && ev_r.kind == EV_WR &&
        ev_r.cmd == CMD_ALERT_MASK;
    assign clr_energy = ev_edge &&
        ((ev_r.kind == EV_STOP && ev_r.cmd == CMD_ENERGY_CLEAR) ||
         (ev_r.kind == EV_RDONE && ev_r.cmd == CMD_ENERGY_READOUT &&
          cfg_r[CFG_AUTOCLR_BIT]));
    assign clr_fault = ev_edge && ev_r.kind == EV_STOP &&
        ev_r.cmd == CMD_CLEAR_FAULTS;

    // bit 6 is stored and read back only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_r <= CFG_RESET;
        end else begin
            if (wr_cfg) cfg_r <= ev_r.data;
            // hardware set beats a software clear
            if (mismatch) cfg_r[CFG_MISMATCH_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mask_r <= MASK_RESET;
        end else if (wr_mask) begin
            mask_r <= ev_r.data;
        end
    end

    // a sample arriving with a clear is dropped
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            accum_r <= 16'h0;
            count_r <= 16'h0;
        end else if (clr_energy) begin
            accum_r <= 16'h0;
            count_r <= 16'h0;
        end else if (sample.valid) begin
            count_r <= count_r + 16'h1;
            if (add_ok) accum_r <= accum_r + sample.power;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            snap_word_r <= 32'h0;
        end else if (ev_edge && ev_r.kind == EV_CMD) begin
            case (ev_r.cmd)
                CMD_DEVICE_CONFIG: snap_word_r <= {24'h0, cfg_r};
                CMD_ALERT_MASK: snap_word_r <= {24'h0, mask_r};
                CMD_MAKER_ID: begin
                    snap_word_r <= {16'h0, MAKER_ID_VALUE};
                end
                CMD_ENERGY_READOUT: snap_word_r <= {count_r, accum_r};
                default: snap_word_r <= 32'h0;
            endcase
        end
    end

    assign alert_cond = |(vendor_status & ~mask_r);
    assign alert_act = cfg_r[CFG_ALERT_LATCH_BIT] ? alert_latch_r
                                                  : alert_cond;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            alert_latch_r <= 1'b0;
            alert_r <= 1'b1;
        end else begin
            if (alert_cond) alert_latch_r <= 1'b1;
            else if (clr_fault) alert_latch_r <= 1'b0;
            // normal polarity drives low when active
            alert_r <= cfg_r[CFG_ALERT_POL_BIT] ? alert_act
                                                : ~alert_act;
        end
    end
    assign alert = alert_r;

endmodule

// *** test/eac_host.sv ***
// Purpose: bus host model driving the two-wire lines of the block
// Assumes: data line has a pull-up, host clock line is push-pull
// Notes: tasks are called from the bench, clock line idles high

`timescale 1ns/1ps

module eac_host (
    input wire logic clock,
    input wire logic sda_line,
    output logic scl,
    output logic sda_rel
);
    // 600 ns half period keeps well clear of the device's sync pipeline
    localparam int HALF = 15;

    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // data moves a few cycles after the fall so it never looks like a start
    task automatic bit_io(input logic b, output logic r);
        sda_rel = b;
        wait_clk(HALF);
        scl = 1'b1;
        wait_clk(HALF);
        r = sda_line;
        scl = 1'b0;
        wait_clk(3);
    endtask

    task automatic start();
        sda_rel = 1'b1;
        wait_clk(HALF);
        scl = 1'b1;
        wait_clk(HALF);
        sda_rel = 1'b0;
        wait_clk(HALF);
        scl = 1'b0;
        wait_clk(3);
    endtask

    task automatic stop();
        sda_rel = 1'b0;
        wait_clk(HALF);
        scl = 1'b1;
        wait_clk(HALF);
        sda_rel = 1'b1;
        wait_clk(HALF);
    endtask

    task automatic byte_tx(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask

    task automatic byte_rx(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(last, r);
    endtask
endmodule

// *** test/eac_energy_accum_config_asserts.sv ***
// Purpose: port-level checks of the energy accumulator config block
// Assumes: raw bus lines sampled on link_clk, bus far slower than it
// Notes: a small decoder follows bytes and bit numbers on the wire

`timescale 1ns/1ps

module eac_energy_accum_config_asserts
    import eac_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire eac_sample_type sample,
    input wire logic [7:0] vendor_status,
    input wire logic alert
);
    logic scl_q, sda_q, rd_r, skip_r, rise, start, stop, host_bit, id_bit;
    logic [3:0] cnt_r, bitno, quiet_r;
    logic [2:0] idx_r;
    logic [7:0] sh_r, cmd_r, idb, vs_q;

    assign rise = scl_in && !scl_q;
    assign start = scl_in && scl_q && sda_q && !sda_in;
    assign stop = scl_in && scl_q && !sda_q && sda_in;
    assign bitno = (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
    assign idb = (idx_r == 3'h1) ? MAKER_ID_VALUE[7:0] : MAKER_ID_VALUE[15:8];
    assign host_bit = rise && (rd_r ? (bitno == 4'h9) : (bitno != 4'h9));
    assign id_bit = rise && rd_r && cmd_r == CMD_MAKER_ID && bitno != 4'h9
        && (idx_r == 3'h1 || idx_r == 3'h2);

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 4'h0;
            idx_r <= 3'h0;
            rd_r <= 1'b0;
            skip_r <= 1'b0;
            sh_r <= 8'h00;
            cmd_r <= 8'h00;
        end else if (start || stop) begin
            cnt_r <= 4'h0;
            idx_r <= 3'h0;
            rd_r <= 1'b0;
            skip_r <= 1'b0;
        end else if (rise) begin
            cnt_r <= bitno;
            if (bitno != 4'h9) begin
                sh_r <= {sh_r[6:0], sda_in};
            end else begin
                if (idx_r != 3'h7)
                    idx_r <= idx_r + 3'h1;
                if (idx_r == 3'h0) begin
                    rd_r <= sh_r[0] && sh_r[7:1] == DEV_ADDR;
                    skip_r <= sh_r[7:1] != DEV_ADDR;
                end
                if (idx_r == 3'h1 && !rd_r)
                    cmd_r <= sh_r;
            end
        end
    end

    // slack covers link sync plus handshake after a stop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            quiet_r <= 4'h0;
            vs_q <= 8'h00;
        end else begin
            vs_q <= vendor_status;
            if (vendor_status != vs_q || !scl_in || !sda_in)
                quiet_r <= 4'h0;
            else if (quiet_r != 4'hf)
                quiet_r <= quiet_r + 4'h1;
        end
    end

    sda_low_a: assert property (
        @(posedge link_clk) disable iff (rst) sda_out == 1'b0)
        else $error("data drive value not low");
    oe_scl_low_a: assert property (
        @(posedge link_clk) disable iff (rst) $changed(sda_oe) |-> !scl_in)
        else $error("data line changed while clock high");
    addr_ack_a: assert property (
        @(posedge link_clk) disable iff (rst)
        rise && bitno == 4'h9 && idx_r == 3'h0 && sh_r[7:1] == DEV_ADDR
        |-> sda_oe [*8]) else $error("own address not acknowledged");
    addr_nak_a: assert property (
        @(posedge link_clk) disable iff (rst)
        rise && bitno == 4'h9 && idx_r == 3'h0 && sh_r[7:1] != DEV_ADDR
        |-> !sda_oe) else $error("foreign address acknowledged");
    skip_quiet_a: assert property (
        @(posedge link_clk) disable iff (rst) skip_r |-> !sda_oe)
        else $error("driving during foreign transfer");
    host_bits_a: assert property (
        @(posedge link_clk) disable iff (rst) host_bit |-> !sda_oe)
        else $error("driving during a host bit");
    id_bits_a: assert property (
        @(posedge link_clk) disable iff (rst)
        id_bit |-> sda_oe == !idb[4'h8 - bitno])
        else $error("id word bit wrong");
    alert_quiet_a: assert property (
        @(posedge clock) disable iff (rst) quiet_r == 4'hf |-> $stable(alert))
        else $error("alert moved without a cause");
endmodule

bind eac_energy_accum_config eac_energy_accum_config_asserts i_asserts (
    .clock(clock),
    .rst(rst),
    .link_clk(link_clk),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .sample(sample),
    .vendor_status(vendor_status),
    .alert(alert)
);

// *** test/eac_tb.sv ***
// Purpose: self-checking bench of the energy accumulator config block
// Assumes: host model drives the bus, bench drives samples and status
// Notes: one bus transfer takes about 300 clocks per byte

`timescale 1ns/1ps

module tb;
    import eac_pkg::*;
    logic clock = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic scl, sda_rel, sda_line, sda_out, sda_oe, alert;
    eac_sample_type sample = '0;
    logic [7:0] vendor_status = 8'h00;
    int n_errors = 0;
    int compares = 0;

    always #20 clock = ~clock;
    always #7.5 link_clk = ~link_clk;
    assign sda_line = sda_rel && !(sda_oe && !sda_out);

    eac_energy_accum_config i_eac_energy_accum_config (
        .clock(clock),
        .rst(rst),
        .link_clk(link_clk),
        .scl_in(scl),
        .sda_in(sda_line),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .sample(sample),
        .vendor_status(vendor_status),
        .alert(alert)
    );

    eac_host i_eac_host (
        .clock(clock),
        .sda_line(sda_line),
        .scl(scl),
        .sda_rel(sda_rel)
    );

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic settle();
        repeat (15) @(posedge clock);
        #1;
    endtask

    task automatic bus_wr(input logic [7:0] cmd, input logic [7:0] d,
                          input int n);
        logic a;
        i_eac_host.start();
        i_eac_host.byte_tx({DEV_ADDR, 1'b0}, a);
        check("addr ack", 32'h1, {31'h0, a});
        i_eac_host.byte_tx(cmd, a);
        for (int i = 0; i < n; i++) begin
            i_eac_host.byte_tx(d, a);
        end
        i_eac_host.stop();
        settle();
    endtask

    task automatic bus_rd(input logic [7:0] cmd, input int n,
                          output logic [31:0] v);
        logic a;
        logic [7:0] b;
        v = '0;
        i_eac_host.start();
        i_eac_host.byte_tx({DEV_ADDR, 1'b0}, a);
        i_eac_host.byte_tx(cmd, a);
        i_eac_host.start();
        i_eac_host.byte_tx({DEV_ADDR, 1'b1}, a);
        for (int i = 0; i < n; i++) begin
            i_eac_host.byte_rx(i == n - 1, b);
            v[8 * i +: 8] = b;
        end
        i_eac_host.stop();
        settle();
    endtask

    task automatic put_sample(input logic n, input logic [15:0] pw,
                              input logic last);
        @(posedge clock);
        #1;
        sample = {1'b1, n, pw};
        if (last) begin
            @(posedge clock);
            #1;
            sample.valid = 1'b0;
        end
    endtask

    task automatic alert_step(input logic [7:0] s, input logic e);
        @(posedge clock);
        #1;
        vendor_status = s;
        repeat (5) @(posedge clock);
        #1;
        check("alert", {31'h0, e}, {31'h0, alert});
    endtask

    task automatic t_reset_values();
        logic [31:0] v;
        bus_rd(CMD_DEVICE_CONFIG, 1, v);
        check("cfg reset", 32'h02, v);
        bus_rd(CMD_MAKER_ID, 2, v);
        check("id", {16'h0, MAKER_ID_VALUE}, v);
        bus_wr(CMD_MAKER_ID, 8'h5a, 2);
        bus_rd(CMD_MAKER_ID, 2, v);
        check("id after write", {16'h0, MAKER_ID_VALUE}, v);
        bus_rd(CMD_ENERGY_READOUT, 4, v);
        check("energy reset", 32'h0, v);
        bus_rd(8'h55, 1, v);
        check("unmapped read", 32'h0, v);
    endtask

    task automatic t_modes();
        logic [31:0] v;
        logic [7:0] cfg;
        logic [15:0] acc;
        for (int m = 0; m < 4; m++) begin
            cfg = 8'(m << 4);
            bus_wr(CMD_DEVICE_CONFIG, cfg, 1);
            bus_wr(CMD_ENERGY_CLEAR, 8'h00, 0);
            put_sample(1'b0, 16'h0110, 1'b0);
            put_sample(1'b1, 16'h0203, 1'b1);
            acc = (m == 1) ? 16'h0110 : (m == 2) ? 16'h0203 : 16'h0313;
            bus_rd(CMD_ENERGY_READOUT, 4, v);
            check("energy", {16'h0002, acc}, v);
            if (m == 1 || m == 2)
                cfg[7] = 1'b1;
            bus_rd(CMD_DEVICE_CONFIG, 1, v);
            check("sign flag", {24'h0, cfg}, v);
        end
    endtask

    task automatic t_autoclear();
        logic [31:0] v;
        bus_wr(CMD_DEVICE_CONFIG, 8'h00, 1);
        bus_wr(CMD_ENERGY_CLEAR, 8'h00, 0);
        put_sample(1'b0, 16'h0042, 1'b1);
        for (int k = 0; k < 2; k++) begin
            bus_rd(CMD_ENERGY_READOUT, 4, v);
            check("energy kept", 32'h0001_0042, v);
        end
        bus_wr(CMD_DEVICE_CONFIG, 8'h04, 1);
        bus_rd(CMD_ENERGY_READOUT, 4, v);
        check("energy read", 32'h0001_0042, v);
        bus_rd(CMD_ENERGY_READOUT, 4, v);
        check("energy cleared", 32'h0, v);
    endtask

    // filter bypassed and reserved bit set: traffic and summing unchanged
    task automatic t_bits();
        logic [31:0] v;
        logic a;
        bus_wr(CMD_DEVICE_CONFIG, 8'h4b, 1);
        bus_wr(CMD_ENERGY_CLEAR, 8'h00, 0);
        put_sample(1'b1, 16'h0007, 1'b1);
        bus_rd(CMD_ENERGY_READOUT, 4, v);
        check("energy bits", 32'h0001_0007, v);
        i_eac_host.start();
        i_eac_host.byte_tx(8'h82, a);
        check("foreign ack", 32'h0, {31'h0, a});
        i_eac_host.byte_tx(CMD_DEVICE_CONFIG, a);
        i_eac_host.byte_tx(8'h00, a);
        i_eac_host.stop();
        bus_rd(CMD_DEVICE_CONFIG, 1, v);
        check("cfg bits", 32'h4b, v);
    endtask

    task automatic t_alert();
        bus_wr(CMD_DEVICE_CONFIG, 8'h00, 1);
        alert_step(8'h01, 1'b0);
        alert_step(8'h00, 1'b1);
        bus_wr(CMD_DEVICE_CONFIG, 8'h01, 1);
        alert_step(8'h01, 1'b1);
        alert_step(8'h00, 1'b0);
        bus_wr(CMD_DEVICE_CONFIG, 8'h02, 1);
        alert_step(8'h01, 1'b0);
        alert_step(8'h00, 1'b0);
        bus_wr(CMD_CLEAR_FAULTS, 8'h00, 0);
        alert_step(8'h00, 1'b1);
        bus_wr(CMD_ALERT_MASK, 8'hf1, 1);
        alert_step(8'h11, 1'b1);
        alert_step(8'h02, 1'b0);
    endtask

    task automatic results();
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (95000) @(posedge clock);
        n_errors++;
        $display("[ERR] watchdog expected finish seen timeout");
        results();
    end

    initial begin
        repeat (20) @(posedge clock);
        #1;
        rst = 1'b0;
        repeat (20) @(posedge clock);
        #1;
        t_reset_values();
        t_modes();
        t_autoclear();
        t_bits();
        t_alert();
        results();
    end
endmodule
